/* File: isrp_pkg.sv */
// Constants and types for the two-wire slave register port
package isrp_pkg;

  // Clock and filter timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYC_INT = (SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [2:0] SPIKE_CYC = 3'(SPIKE_CYC_INT < 1 ? 1 : SPIKE_CYC_INT);

  // Bus rates served (bit/s); high-speed mode is not offered
  localparam int FAST_RATE_BPS = 400000;
  localparam int FAST_PLUS_RATE_BPS = 1000000;
  localparam int P2P_RATE_BAUD = 5000000;

  // Slave address layout
  localparam logic [4:0] SLAVE_ADDR_HI = 5'h0a;
  localparam int ADDR_HI_POS = 2;
  localparam int RW_BIT_POS = 0;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;

  // Register pointer
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] FIFO_REG_ADDR = 8'h05;
  localparam logic [REG_AW-1:0] PTR_RESET = 8'h00;
  localparam logic [REG_AW-1:0] PTR_STEP = 8'h01;

  // Bit counter
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Protocol states
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_ADDR    = 4'b0001,
    ST_ADDR_AK = 4'b0010,
    ST_REG     = 4'b0011,
    ST_REG_AK  = 4'b0100,
    ST_WR      = 4'b0101,
    ST_WR_AK   = 4'b0110,
    ST_RD      = 4'b0111,
    ST_RD_AK   = 4'b1000,
    ST_SKIP    = 4'b1001
  } isrp_state_t;

endpackage

/* File: isrp_top.sv */
// Two-wire slave port giving an external master access to internal registers
`timescale 1ns/1ps
module isrp_top
  import isrp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Bus pins
  input  wire logic scl_pin,
  input  wire logic sda_pin,
  output logic sda_drive,
  output logic sda_en,
  // Data keeper
  output logic keeper_level,
  output logic keeper_en,
  // Configuration
  input  wire logic if_selected,
  input  wire logic p2p_mode,
  input  wire logic use_nvm_addr,
  input  wire logic [1:0] nvm_addr,
  input  wire logic [1:0] addr_pin,
  // Register access
  output logic wr_stb,
  output logic [REG_AW-1:0] wr_addr,
  output logic [7:0] wr_data,
  output logic rd_stb,
  output logic [REG_AW-1:0] rd_addr,
  input  wire logic [7:0] rd_data,
  // Status
  output logic bus_busy,
  output logic selected
);

  // No clock pin output exists: the clock line is never driven

  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic [1:0] apin0_s_q;
  logic [1:0] apin1_s_q;
  logic scl_f_q;
  logic sda_f_q;
  logic [2:0] scl_cnt_q;
  logic [2:0] sda_cnt_q;
  logic scl_p_q;
  logic sda_p_q;
  isrp_state_t state_q;
  logic [2:0] bit_q;
  logic full_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] rd_buf_q;
  logic rd_cap_q;
  logic [REG_AW-1:0] ptr_q;
  logic busy_q;
  logic sel_q;
  logic wr_stb_q;
  logic [REG_AW-1:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic rd_stb_q;
  logic [REG_AW-1:0] rd_addr_q;
  logic sda_drive_q;
  logic sda_en_q;
  logic keep_q;

  logic rise;
  logic fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] byte_in;
  logic [1:0] low_bits;
  logic [6:0] own_addr;
  logic addr_match;
  logic at_fifo;
  logic [REG_AW-1:0] ptr_next;
  logic ack_phase;
  logic tx_phase;
  logic want_en;

  // Two-stage synchronisers; short latency keeps pace with 1 Mbit/s
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      apin0_s_q <= 2'h0;
      apin1_s_q <= 2'h0;
    end
    else if (ce)
    begin
      scl_s_q <= {scl_s_q[0], scl_pin};
      sda_s_q <= {sda_s_q[0], sda_pin};
      apin0_s_q <= {apin0_s_q[0], addr_pin[0]};
      apin1_s_q <= {apin1_s_q[0], addr_pin[1]};
    end
  end

  // Spike suppression: a level must persist before it is taken
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_f_q <= 1'b1;
      scl_cnt_q <= 3'h0;
    end
    else if (ce)
    begin
      if (!if_selected || scl_s_q[1] == scl_f_q)
      begin
        scl_f_q <= scl_s_q[1];
        scl_cnt_q <= 3'h0;
      end
      else if (scl_cnt_q + 3'h1 >= SPIKE_CYC)
      begin
        scl_f_q <= scl_s_q[1];
        scl_cnt_q <= 3'h0;
      end
      else
      begin
        scl_cnt_q <= scl_cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sda_f_q <= 1'b1;
      sda_cnt_q <= 3'h0;
    end
    else if (ce)
    begin
      if (!if_selected || sda_s_q[1] == sda_f_q)
      begin
        sda_f_q <= sda_s_q[1];
        sda_cnt_q <= 3'h0;
      end
      else if (sda_cnt_q + 3'h1 >= SPIKE_CYC)
      begin
        sda_f_q <= sda_s_q[1];
        sda_cnt_q <= 3'h0;
      end
      else
      begin
        sda_cnt_q <= sda_cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else if (ce)
    begin
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end

  // Bus events
  assign rise = scl_f_q && !scl_p_q;
  assign fall = !scl_f_q && scl_p_q;
  assign start_cond = scl_f_q && scl_p_q && sda_p_q && !sda_f_q;
  assign stop_cond = scl_f_q && scl_p_q && !sda_p_q && sda_f_q;
  assign byte_in = {shift_q[6:0], sda_f_q};

  // Own address; fixed upper part excludes general call and device-ID codes
  always_comb
  begin
    if (use_nvm_addr)
      low_bits = nvm_addr;
    else if (p2p_mode)
      low_bits = {1'b0, apin0_s_q[1]};
    else
      low_bits = {apin1_s_q[1], apin0_s_q[1]};
  end

  assign own_addr = {SLAVE_ADDR_HI, low_bits};
  assign addr_match = byte_in[7:1] == own_addr;
  assign at_fifo = ptr_q == FIFO_REG_ADDR;
  assign ptr_next = at_fifo ? ptr_q : ptr_q + PTR_STEP;

  // Bus occupancy
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      busy_q <= 1'b0;
    else if (ce)
    begin
      if (start_cond)
        busy_q <= 1'b1;
      else if (stop_cond)
        busy_q <= 1'b0;
    end
  end

  // Protocol sequencer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      bit_q <= 3'h0;
      full_q <= 1'b0;
      shift_q <= 8'h00;
      sel_q <= 1'b0;
    end
    else if (ce)
    begin
      if (start_cond)
      begin
        state_q <= ST_ADDR;
        bit_q <= 3'h0;
        full_q <= 1'b0;
        sel_q <= 1'b0;
      end
      else if (stop_cond)
      begin
        state_q <= ST_IDLE;
        full_q <= 1'b0;
        sel_q <= 1'b0;
      end
      else if (rise)
      begin
        case (state_q)
          ST_ADDR, ST_REG, ST_WR:
          begin
            shift_q <= byte_in;
            bit_q <= bit_q + 3'h1;
            if (bit_q == LAST_BIT)
            begin
              if (state_q == ST_ADDR && !addr_match)
                state_q <= ST_SKIP;
              else
                full_q <= 1'b1;
              if (state_q == ST_ADDR && addr_match)
                sel_q <= 1'b1;
            end
          end
          ST_RD:
          begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == LAST_BIT)
              full_q <= 1'b1;
          end
          ST_RD_AK:
          begin
            shift_q <= {7'h00, sda_f_q};
          end
          default:
          begin
            bit_q <= bit_q;
          end
        endcase
      end
      else if (fall)
      begin
        full_q <= 1'b0;
        bit_q <= 3'h0;
        case (state_q)
          ST_ADDR:
            if (full_q)
              state_q <= ST_ADDR_AK;
          ST_REG:
            if (full_q)
              state_q <= ST_REG_AK;
          ST_WR:
            if (full_q)
              state_q <= ST_WR_AK;
          ST_RD:
            if (full_q)
              state_q <= ST_RD_AK;
          ST_ADDR_AK:
            state_q <= (shift_q[RW_BIT_POS] == RW_READ) ? ST_RD : ST_REG;
          ST_REG_AK:
            state_q <= ST_WR;
          ST_WR_AK:
            state_q <= ST_WR;
          ST_RD_AK:
            state_q <= shift_q[0] ? ST_SKIP : ST_RD;
          default:
            state_q <= state_q;
        endcase
        if (!full_q && (state_q == ST_ADDR || state_q == ST_REG || state_q == ST_WR
            || state_q == ST_RD))
          bit_q <= bit_q;
      end
    end
  end

  // Register pointer and access strobes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ptr_q <= PTR_RESET;
      wr_stb_q <= 1'b0;
      wr_addr_q <= PTR_RESET;
      wr_data_q <= 8'h00;
      rd_stb_q <= 1'b0;
      rd_addr_q <= PTR_RESET;
    end
    else if (ce)
    begin
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      if (rise && !start_cond && !stop_cond)
      begin
        if (bit_q == LAST_BIT && state_q == ST_REG)
          ptr_q <= byte_in;
        if (bit_q == LAST_BIT && state_q == ST_WR)
        begin
          wr_stb_q <= 1'b1;
          wr_addr_q <= ptr_q;
          wr_data_q <= byte_in;
          ptr_q <= ptr_next;
        end
        if ((bit_q == LAST_BIT && state_q == ST_ADDR && addr_match
             && byte_in[RW_BIT_POS] == RW_READ)
            || (state_q == ST_RD_AK && !sda_f_q))
        begin
          rd_stb_q <= 1'b1;
          rd_addr_q <= ptr_q;
          ptr_q <= ptr_next;
        end
      end
    end
  end

  // Read data capture and serialiser
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_cap_q <= 1'b0;
      rd_buf_q <= 8'h00;
      tx_q <= 8'hff;
    end
    else if (ce)
    begin
      rd_cap_q <= rd_stb_q;
      if (rd_cap_q)
        rd_buf_q <= rd_data;
      if (fall && !start_cond && !stop_cond)
      begin
        if ((state_q == ST_ADDR_AK && shift_q[RW_BIT_POS] == RW_READ)
            || (state_q == ST_RD_AK && !shift_q[0]))
          tx_q <= rd_buf_q;
        else if (state_q == ST_RD && !full_q)
          tx_q <= {tx_q[6:0], 1'b1};
      end
    end
  end

  // Data line drive
  assign ack_phase = state_q == ST_ADDR_AK || state_q == ST_REG_AK || state_q == ST_WR_AK;
  // Held through the last bit's high phase, released only after the fall
  assign tx_phase = state_q == ST_RD;

  always_comb
  begin
    if (p2p_mode)
      want_en = (ack_phase || tx_phase) && !scl_f_q;
    else
      want_en = ack_phase || (tx_phase && !tx_q[7]);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sda_en_q <= 1'b0;
      sda_drive_q <= 1'b1;
    end
    else if (ce)
    begin
      sda_en_q <= want_en;
      if (ack_phase)
        sda_drive_q <= 1'b0;
      else if (p2p_mode)
        sda_drive_q <= tx_q[7];
      else
        sda_drive_q <= 1'b0;
    end
  end

  // Keeper follows the line while clock is low and holds while high
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      keep_q <= 1'b1;
    else if (ce)
    begin
      if (!scl_f_q)
        keep_q <= sda_f_q;
    end
  end

  assign sda_drive = sda_drive_q;
  assign sda_en = sda_en_q;
  assign keeper_level = keep_q;
  assign keeper_en = p2p_mode;
  assign wr_stb = wr_stb_q;
  assign wr_addr = wr_addr_q;
  assign wr_data = wr_data_q;
  assign rd_stb = rd_stb_q;
  assign rd_addr = rd_addr_q;
  assign bus_busy = busy_q;
  assign selected = sel_q;

endmodule

/* File: isrp_top_asserts.sv */
// Concurrent checks on the two-wire slave register port
`timescale 1ns/1ps
module isrp_top_asserts
  import isrp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Bus pins and keeper
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic sda_drive,
  input wire logic sda_en,
  input wire logic keeper_level,
  input wire logic keeper_en,
  // Configuration
  input wire logic if_selected,
  input wire logic p2p_mode,
  input wire logic use_nvm_addr,
  input wire logic [1:0] nvm_addr,
  input wire logic [1:0] addr_pin,
  // Register access
  input wire logic wr_stb,
  input wire logic [REG_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic rd_stb,
  input wire logic [REG_AW-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  // Status
  input wire logic bus_busy,
  input wire logic selected
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_quiet;
    (!wr_stb && !rd_stb) [*8];
  endsequence
  sequence s_start;
    $fell(sda_pin) && scl_pin && $past(scl_pin);
  endsequence
  sequence s_stop;
    $rose(sda_pin) && scl_pin && $past(scl_pin);
  endsequence
  sequence s_scl_high;
    scl_pin [*6];
  endsequence
  a_wr_spacing: assert property (wr_stb |=> s_quiet)
    else $error("write strobes too close");
  a_rd_spacing: assert property (rd_stb |=> s_quiet)
    else $error("read strobes too close");
  a_start_busy: assert property (s_start |-> ##[1:12] bus_busy)
    else $error("start not seen");
  a_stop_free: assert property (s_stop |-> ##[1:12] !bus_busy)
    else $error("stop not seen");
  a_od_zero: assert property (sda_en && !p2p_mode |-> !sda_drive)
    else $error("open drain drove high");
  a_drive_low: assert property ($changed(sda_en) && !p2p_mode |-> !scl_pin)
    else $error("data changed with clock high");
  a_match_busy: assert property ($rose(selected) |-> bus_busy)
    else $error("selected outside a frame");
  a_unsel_quiet: assert property (!selected && !$past(selected) |-> !sda_en && !wr_stb)
    else $error("activity while not addressed");
  a_keeper_hold: assert property (s_scl_high |-> $stable(keeper_level))
    else $error("keeper moved while clock high");
endmodule

bind isrp_top isrp_top_asserts u_chk (
  .clk(clk), .rst(rst), .ce(ce), .scl_pin(scl_pin), .sda_pin(sda_pin),
  .sda_drive(sda_drive), .sda_en(sda_en), .keeper_level(keeper_level),
  .keeper_en(keeper_en), .if_selected(if_selected), .p2p_mode(p2p_mode),
  .use_nvm_addr(use_nvm_addr), .nvm_addr(nvm_addr), .addr_pin(addr_pin),
  .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .rd_stb(rd_stb),
  .rd_addr(rd_addr), .rd_data(rd_data), .bus_busy(bus_busy), .selected(selected)
);

/* File: isrp_host_model.sv */
// Bus master model for the two-wire port at 1 Mbit/s
`timescale 1ns/1ps
module isrp_host_model
(
  // Clock and resolved data line
  input wire logic clk,
  input wire logic sda_line,
  // Master drives; high means released
  output logic scl,
  output logic sda_m
);
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Quarter bit, 10 cycles
  task automatic q;
    repeat (10) @(posedge clk);
    #2;
  endtask
  task automatic start;
    sda_m = 1'b1;
    q;
    scl = 1'b1;
    q;
    sda_m = 1'b0;
    q;
    scl = 1'b0;
    q;
  endtask
  task automatic stop;
    sda_m = 1'b0;
    q;
    scl = 1'b1;
    q;
    sda_m = 1'b1;
    q;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    q;
    scl = 1'b1;
    q;
    r = sda_line;
    q;
    scl = 1'b0;
    q;
  endtask
  // Eight bits MSB first, then the acknowledge bit
  task automatic byte_io(input logic [7:0] d, input logic ak, output logic [7:0] r,
    output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(ak, a);
  endtask
endmodule

/* File: testbench.sv */
// Self-checking bench for the two-wire slave register port
`timescale 1ns/1ps
module testbench;
  import isrp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic use_nvm_addr = 1'b0;
  logic [1:0] nvm_addr = 2'h0;
  logic [1:0] addr_pin = 2'h0;
  logic p2p_mode = 1'b0;
  logic [7:0] rd_data;
  logic scl_pin, sda_m, sda_pin, sda_drive, sda_en, keeper_level, keeper_en;
  logic wr_stb, rd_stb, bus_busy, selected;
  logic [REG_AW-1:0] wr_addr, rd_addr;
  logic [7:0] wr_data;
  logic [7:0] mem [256];
  logic [31:0] seed = 32'h000075aa;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int wr_cnt = 0;
  // Pull-up wire: low if either side pulls
  assign sda_pin = sda_m & ~(sda_en & ~sda_drive);
  assign rd_data = mem[rd_addr];
  isrp_top dut (.clk(clk), .rst(rst), .ce(1'b1), .scl_pin(scl_pin), .sda_pin(sda_pin),
    .sda_drive(sda_drive), .sda_en(sda_en), .keeper_level(keeper_level),
    .keeper_en(keeper_en), .if_selected(1'b1), .p2p_mode(p2p_mode),
    .use_nvm_addr(use_nvm_addr), .nvm_addr(nvm_addr), .addr_pin(addr_pin),
    .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .rd_stb(rd_stb),
    .rd_addr(rd_addr), .rd_data(rd_data), .bus_busy(bus_busy), .selected(selected));
  isrp_host_model m (.clk(clk), .sda_line(sda_pin), .scl(scl_pin), .sda_m(sda_m));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (wr_stb === 1'b1)
    begin
      mem[wr_addr] <= wr_data;
      wr_cnt <= wr_cnt + 1;
    end
    if (cyc == 40000)
    begin
      miscompares++;
      summarize();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic rnd(output logic [7:0] v);
    seed = xs(seed);
    v = seed[7:0];
  endtask
  // Pointer and data expected for the k-th byte of a frame
  function automatic logic [7:0] ep(input logic [7:0] r, input int k);
    return (r == FIFO_REG_ADDR) ? r : r + 8'(k);
  endfunction
  function automatic logic [7:0] xd(input logic [7:0] r, input logic [2:0][7:0] d, input int k);
    return d[(r == FIFO_REG_ADDR) ? 2 : k];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] d, input logic ack_exp);
    logic [7:0] r;
    logic a;
    m.byte_io(d, 1'b1, r, a);
    chk({7'h00, a}, {7'h00, ack_exp});
  endtask
  task automatic recv(input logic [7:0] exp, input logic nack);
    logic [7:0] v;
    logic a;
    m.byte_io(8'hff, nack, v, a);
    chk(v, exp);
  endtask
  task automatic summarize;
    $display("compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    logic [7:0] r, lo8;
    logic [2:0][7:0] d;
    logic [6:0] dev;
    logic ak;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (6) @(posedge clk);
    #2 rst = 1'b0;
    repeat (10) @(posedge clk);
    // Pin or stored low address bits; plain register or FIFO
    for (int i = 0; i < 4; i++)
    begin
      rnd(lo8);
      use_nvm_addr = i[0];
      nvm_addr = i[0] ? lo8[1:0] : ~lo8[1:0];
      addr_pin = i[0] ? ~lo8[1:0] : lo8[1:0];
      dev = {SLAVE_ADDR_HI, lo8[1:0]};
      rnd(r);
      r = i[1] ? FIFO_REG_ADDR : {2'b01, r[5:0]};
      m.start();
      chk({7'h00, bus_busy}, 8'h01);
      send({dev, RW_WRITE}, 1'b0);
      send(r, 1'b0);
      for (int k = 0; k < 3; k++)
      begin
        rnd(d[k]);
        send(d[k], 1'b0);
      end
      m.stop();
      chk({7'h00, bus_busy}, 8'h00);
      for (int k = 0; k < 3; k++) chk(mem[ep(r, k)], xd(r, d, k));
      m.start();
      send({dev, RW_WRITE}, 1'b0);
      send(r, 1'b0);
      m.start();
      send({dev, RW_READ}, 1'b0);
      for (int k = 0; k < 3; k++) recv(xd(r, d, k), k == 2);
      chk({7'h00, sda_en}, 8'h00);
      m.stop();
      m.start();
      send(i == 1 ? 8'h00 : i == 2 ? 8'hf8 : {SLAVE_ADDR_HI, ~lo8[1:0], i == 3}, 1'b1);
      send(r, 1'b1);
      m.stop();
      chk(8'(wr_cnt), 8'(3 * (i + 1)));
      $display("test %0d done, mismatches %0d", i, miscompares);
    end
    // Point-to-point pin addressing: upper configurable bit reads as 0
    chk({7'h00, keeper_en}, 8'h00);
    p2p_mode = 1'b1;
    use_nvm_addr = 1'b0;
    addr_pin = 2'h3;
    repeat (10) @(posedge clk);
    #2;
    chk({7'h00, keeper_en}, 8'h01);
    for (int j = 0; j < 2; j++)
    begin
      lo8 = {SLAVE_ADDR_HI, j[0], 1'b1, RW_WRITE};
      m.start();
      for (int b = 7; b >= 0; b--) m.bit_io(lo8[b], r[b]);
      chk({7'h00, selected}, {7'h00, ~j[0]});
      // Master keeps data low over the acknowledge; this wire has no keeper
      m.bit_io(1'b0, ak);
      m.stop();
    end
    $display("test 4 done, mismatches %0d", miscompares);
    summarize();
  end
endmodule
